/* File: core/axis_ctrl_pkg.sv */
// Constants, codes and types shared by the axis mode and setting control.
// Assumes one 20 MHz clock domain; no bus, all controls are plain ports.
package axis_ctrl_pkg;
  // Position word
  localparam int POS_W = 32;
  typedef logic signed [POS_W-1:0] pos_t;

  // Operating mode select codes
  localparam logic [1:0] MODE_JOG = 2'h0;
  localparam logic [1:0] MODE_REL = 2'h1;
  localparam logic [1:0] MODE_ABS = 2'h2;
  localparam logic [1:0] MODE_REF = 2'h3;

  // Setting select codes
  localparam logic [1:0] SET_ACTUAL = 2'h0;
  localparam logic [1:0] SET_SHIFT = 2'h1;
  localparam logic [1:0] SET_CLEAR = 2'h2;
  localparam logic [1:0] SET_REFPT = 2'h3;

  // Reset values
  localparam pos_t OFFSET_RST = 32'h0;
  localparam pos_t POS_RST = 32'h0;

  // Overshoot distance used to approach a target from the fixed side
  localparam pos_t APPROACH_GAP = 32'h10;

  // Pin synchroniser: key positive, key negative, enable input, reference mark
  localparam int PIN_W = 4;
  localparam int PIN_KEYP = 0;
  localparam int PIN_KEYN = 1;
  localparam int PIN_EN = 2;
  localparam int PIN_REF = 3;

  // Channel states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_JOG,
    ST_PRE,
    ST_MOVE,
    ST_SEEK
  } axis_state_e;
endpackage

/* File: core/axis_mode_and_setting_control.sv */
// Mode and setting supervisor for one positioning channel.
// Assumes a raw position count from the encoder logic on mclk and
// asynchronous key, enable and reference-mark pins.
`timescale 1ns/1ps
module axis_mode_and_setting_control (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Machine data load
  input wire logic paramLoad,
  input wire logic paramOk,
  // Operating mode call
  input wire logic [1:0] modeSel,
  input wire logic startCmd,
  input wire logic stopCmd,
  input wire logic driveEnable,
  input wire axis_ctrl_pkg::pos_t incValue,
  input wire logic refDirNeg,
  input wire axis_ctrl_pkg::pos_t refCoord,
  // Pins
  input wire logic keyPos,
  input wire logic keyNeg,
  input wire logic enableIn,
  input wire logic refMark,
  // Settings
  input wire logic setReq,
  input wire logic [1:0] setSel,
  input wire axis_ctrl_pkg::pos_t setValue,
  // Single settings
  input wire logic approachOn,
  input wire logic approachOff,
  input wire logic approachNeg,
  input wire logic ignoreEnOn,
  input wire logic ignoreEnOff,
  // Position count from the encoder logic
  input wire axis_ctrl_pkg::pos_t posCount,
  // Drive side
  output logic driveFwd,
  output logic driveRev,
  // Status
  output logic paramValid,
  output logic modeActive,
  output logic synced,
  output logic startRefused,
  output logic distError,
  output logic modeDone,
  output logic modeAborted,
  output logic setDone,
  output logic setRefused,
  output logic approachActive,
  output logic approachDirNeg,
  output logic ignoreEnable,
  output axis_ctrl_pkg::pos_t actualPosition,
  output axis_ctrl_pkg::pos_t offset
);
  axis_ctrl_pkg::axis_state_e state_q, state_d;
  axis_ctrl_pkg::pos_t target_q, via_q, goal, entry, viaNow, targetNow;
  logic [axis_ctrl_pkg::PIN_W-1:0] pins;
  logic keyP, keyN, keyP_q, keyN_q, refSeen_q, jogNeg_q, seekNeg_q, jogNegNow, seekNegNow;
  logic launch, enOk, condOk, relNeg, go, refHit, setGo, abortNow;
  // Target of a move: coordinate or displacement from the start point
  function automatic axis_ctrl_pkg::pos_t calcGoal(input logic [1:0] m,
      input axis_ctrl_pkg::pos_t inc, input axis_ctrl_pkg::pos_t pos);
    calcGoal = (m == axis_ctrl_pkg::MODE_ABS) ? inc : pos + inc;
  endfunction
  // First point of a move: past the goal when arriving from the wrong side
  function automatic axis_ctrl_pkg::pos_t calcEntry(input logic on, input logic neg,
      input axis_ctrl_pkg::pos_t g, input axis_ctrl_pkg::pos_t pos);
    calcEntry = g;
    if (on && !neg && g < pos) begin
      calcEntry = g - axis_ctrl_pkg::APPROACH_GAP;
    end else if (on && neg && g > pos) begin
      calcEntry = g + axis_ctrl_pkg::APPROACH_GAP;
    end
  endfunction

  pin_sync pinSync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pinIn({refMark, enableIn, keyNeg, keyPos}),
    .pinOut(pins)
  );
  assign keyP = pins[axis_ctrl_pkg::PIN_KEYP];
  assign keyN = pins[axis_ctrl_pkg::PIN_KEYN];
  assign enOk = pins[axis_ctrl_pkg::PIN_EN] || ignoreEnable;
  // Jogging starts on a key press, the other modes on the start command
  assign launch = (modeSel == axis_ctrl_pkg::MODE_JOG) ?
    ((keyP && !keyP_q) || (keyN && !keyN_q)) : startCmd;
  assign relNeg = (modeSel == axis_ctrl_pkg::MODE_REL) && incValue < 0;
  assign condOk = paramValid && (state_q == axis_ctrl_pkg::ST_IDLE) && driveEnable && enOk;
  assign go = launch && condOk && !relNeg;
  assign goal = calcGoal(modeSel, incValue, actualPosition);
  assign entry = calcEntry(approachActive, approachDirNeg, goal, actualPosition);
  assign refHit = (state_q == axis_ctrl_pkg::ST_SEEK) && pins[axis_ctrl_pkg::PIN_REF] && !refSeen_q;
  assign setGo = setReq && paramValid;
  assign abortNow = (state_q != axis_ctrl_pkg::ST_IDLE) && (!driveEnable || stopCmd);
  // Launch cycle drives from the values being latched, not the stale ones
  assign jogNegNow = (state_q == axis_ctrl_pkg::ST_IDLE) ? (keyN && !keyN_q) : jogNeg_q;
  assign seekNegNow = (state_q == axis_ctrl_pkg::ST_IDLE) ? refDirNeg : seekNeg_q;
  assign viaNow = (state_q == axis_ctrl_pkg::ST_IDLE) ? entry : via_q;
  assign targetNow = (state_q == axis_ctrl_pkg::ST_IDLE) ? goal : target_q;

  // Machine data status
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      paramValid <= 1'b0;
    end else if (paramLoad) begin
      paramValid <= paramOk;
    end
  end

  // Key and reference-mark history for edge detection
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      keyP_q <= 1'b0;
      keyN_q <= 1'b0;
      refSeen_q <= 1'b0;
    end else begin
      keyP_q <= keyP;
      keyN_q <= keyN;
      refSeen_q <= pins[axis_ctrl_pkg::PIN_REF];
    end
  end

  // Next state of the channel
  always_comb begin
    state_d = state_q;
    case (state_q)
      axis_ctrl_pkg::ST_IDLE: begin
        if (go) begin
          case (modeSel)
            axis_ctrl_pkg::MODE_JOG: state_d = axis_ctrl_pkg::ST_JOG;
            axis_ctrl_pkg::MODE_REF: state_d = axis_ctrl_pkg::ST_SEEK;
            default: state_d = (entry != goal) ? axis_ctrl_pkg::ST_PRE : axis_ctrl_pkg::ST_MOVE;
          endcase
        end
      end
      axis_ctrl_pkg::ST_JOG: begin
        if ((jogNeg_q && !keyN) || (!jogNeg_q && !keyP)) begin
          state_d = axis_ctrl_pkg::ST_IDLE;
        end
      end
      axis_ctrl_pkg::ST_PRE: begin
        if (actualPosition == via_q) begin
          state_d = axis_ctrl_pkg::ST_MOVE;
        end
      end
      axis_ctrl_pkg::ST_MOVE: begin
        if (actualPosition == target_q) begin
          state_d = axis_ctrl_pkg::ST_IDLE;
        end
      end
      axis_ctrl_pkg::ST_SEEK: begin
        if (refHit) begin
          state_d = axis_ctrl_pkg::ST_IDLE;
        end
      end
      default: state_d = axis_ctrl_pkg::ST_IDLE;
    endcase
    if (abortNow) begin
      state_d = axis_ctrl_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= axis_ctrl_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Move targets and directions latched at launch
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      target_q <= axis_ctrl_pkg::POS_RST;
      via_q <= axis_ctrl_pkg::POS_RST;
      jogNeg_q <= 1'b0;
      seekNeg_q <= 1'b0;
    end else if (go) begin
      target_q <= goal;
      via_q <= entry;
      jogNeg_q <= keyN && !keyN_q;
      seekNeg_q <= refDirNeg;
    end
  end

  // Drive outputs; idle leaves the axis standing
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      driveFwd <= 1'b0;
      driveRev <= 1'b0;
    end else begin
      case (state_d)
        axis_ctrl_pkg::ST_JOG: begin
          driveFwd <= !jogNegNow;
          driveRev <= jogNegNow;
        end
        axis_ctrl_pkg::ST_PRE: begin
          driveFwd <= viaNow > actualPosition;
          driveRev <= viaNow < actualPosition;
        end
        axis_ctrl_pkg::ST_MOVE: begin
          driveFwd <= targetNow > actualPosition;
          driveRev <= targetNow < actualPosition;
        end
        axis_ctrl_pkg::ST_SEEK: begin
          driveFwd <= !seekNegNow;
          driveRev <= seekNegNow;
        end
        default: begin
          driveFwd <= 1'b0;
          driveRev <= 1'b0;
        end
      endcase
    end
  end

  // Mode status and one-cycle events
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      modeActive <= 1'b0;
      startRefused <= 1'b0;
      distError <= 1'b0;
      modeDone <= 1'b0;
      modeAborted <= 1'b0;
    end else begin
      modeActive <= state_d != axis_ctrl_pkg::ST_IDLE;
      startRefused <= launch && !go;
      distError <= launch && condOk && relNeg;
      modeDone <= !abortNow && state_q != axis_ctrl_pkg::ST_IDLE && state_d == axis_ctrl_pkg::ST_IDLE;
      modeAborted <= abortNow;
    end
  end

  // Coordinate offset and synchronisation
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      offset <= axis_ctrl_pkg::OFFSET_RST;
      synced <= 1'b0;
    end else if (refHit) begin
      offset <= refCoord - posCount;
      synced <= 1'b1;
    end else if (setGo) begin
      case (setSel)
        axis_ctrl_pkg::SET_ACTUAL: offset <= setValue - posCount;
        axis_ctrl_pkg::SET_SHIFT: offset <= offset + setValue;
        axis_ctrl_pkg::SET_CLEAR: offset <= axis_ctrl_pkg::OFFSET_RST;
        default: begin
          offset <= setValue - posCount;
          synced <= 1'b1;
        end
      endcase
    end
  end

  // Setting answers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      setDone <= 1'b0;
      setRefused <= 1'b0;
    end else begin
      setDone <= setGo && !refHit;
      setRefused <= setReq && !setGo;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      actualPosition <= axis_ctrl_pkg::POS_RST;
    end else begin
      actualPosition <= posCount + offset;
    end
  end

  // Single settings; with machine data valid, switching on wins over switching off
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      approachActive <= 1'b0;
      approachDirNeg <= 1'b0;
      ignoreEnable <= 1'b0;
    end else begin
      if (paramValid && approachOn) begin
        approachActive <= 1'b1;
        approachDirNeg <= approachNeg;
      end else if (approachOff) begin
        approachActive <= 1'b0;
      end
      if (paramValid && ignoreEnOn) begin
        ignoreEnable <= 1'b1;
      end else if (ignoreEnOff) begin
        ignoreEnable <= 1'b0;
      end
    end
  end
  refuse_noparam_a: assert property (@(posedge mclk) disable iff (!reset_n)
    launch && !paramValid |=> startRefused && !modeActive)
    else $error("start accepted without machine data");
  start_cond_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(modeActive) |-> $past(driveEnable) && $past(paramValid) && $past(enOk))
    else $error("mode began with a start condition unmet");
  enable_pin_a: assert property (@(posedge mclk) disable iff (!reset_n)
    launch && !pins[axis_ctrl_pkg::PIN_EN] && !ignoreEnable |=> startRefused)
    else $error("start not refused with enable input low");
  start_cmd_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(modeActive) |-> $past(launch))
    else $error("mode began without a start command");
  idle_still_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !modeActive |-> !driveFwd && !driveRev)
    else $error("drive moving while no mode active");
  jog_release_a: assert property (@(posedge mclk) disable iff (!reset_n)
    state_q == axis_ctrl_pkg::ST_JOG && !jogNeg_q && !keyP && !abortNow |=>
      state_q == axis_ctrl_pkg::ST_IDLE && !driveFwd)
    else $error("jog continued after key release");
  rel_target_a: assert property (@(posedge mclk) disable iff (!reset_n)
    go && modeSel == axis_ctrl_pkg::MODE_REL |=> target_q == $past(actualPosition) + $past(incValue))
    else $error("relative target not start plus displacement");
  abs_target_a: assert property (@(posedge mclk) disable iff (!reset_n)
    go && modeSel == axis_ctrl_pkg::MODE_ABS |=> target_q == $past(incValue))
    else $error("absolute target not the given coordinate");
  neg_rel_a: assert property (@(posedge mclk) disable iff (!reset_n)
    launch && condOk && relNeg |=> distError && !modeActive)
    else $error("negative relative increment not refused");
  busy_refuse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    launch && state_q != axis_ctrl_pkg::ST_IDLE |=> startRefused)
    else $error("start accepted while a mode runs");
  set_refuse_a: assert property (@(posedge mclk) disable iff (!reset_n)
    setReq && !paramValid |=> setRefused && $stable(offset))
    else $error("setting acted on unparameterized channel");
  offset_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !setGo && !refHit |=> $stable(offset))
    else $error("offset changed without a setting");
  ref_sync_a: assert property (@(posedge mclk) disable iff (!reset_n)
    refHit && !abortNow |=> synced && offset == $past(refCoord) - $past(posCount))
    else $error("reference mark did not synchronise axis");
  jog_run_c: cover property (@(posedge mclk) disable iff (!reset_n)
    state_q == axis_ctrl_pkg::ST_JOG ##1 state_q == axis_ctrl_pkg::ST_IDLE);
  move_done_c: cover property (@(posedge mclk) disable iff (!reset_n)
    state_q == axis_ctrl_pkg::ST_PRE ##[1:200] modeDone);
  ref_done_c: cover property (@(posedge mclk) disable iff (!reset_n) refHit);
  set_actual_c: cover property (@(posedge mclk) disable iff (!reset_n)
    setGo && setSel == axis_ctrl_pkg::SET_ACTUAL);
endmodule

/* File: core/pin_sync.sv */
// Three-stage synchroniser for pins entering the mclk domain.
// Assumes asynchronous pins; output changes once stages two and three agree.
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Pins and synchronised levels
  input wire logic [axis_ctrl_pkg::PIN_W-1:0] pinIn,
  output logic [axis_ctrl_pkg::PIN_W-1:0] pinOut
);
  logic [axis_ctrl_pkg::PIN_W-1:0] s1_q;
  logic [axis_ctrl_pkg::PIN_W-1:0] s2_q;
  logic [axis_ctrl_pkg::PIN_W-1:0] s3_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a level only when the last two stages agree
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinOut <= '0;
    end else begin
      for (int i = 0; i < axis_ctrl_pkg::PIN_W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pinOut[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

/* File: dv/axis_drive_model.sv */
// Drive and encoder stand-in for the axis supervisor.
// Assumes drive outputs on mclk; moves one count every four cycles while driven.
`timescale 1ns/1ps
module axis_drive_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Drive commands
  input wire logic driveFwd,
  input wire logic driveRev,
  // Encoder count
  output axis_ctrl_pkg::pos_t posCount
);
  logic [1:0] stepDiv_q;
  axis_ctrl_pkg::pos_t pos_q;
  assign posCount = pos_q;
  // Slow stepping so a stop lands before the next count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stepDiv_q <= 2'h0;
      pos_q <= 32'h0;
    end else begin
      stepDiv_q <= stepDiv_q + 2'h1;
      if (stepDiv_q == 2'h3 && driveFwd && !driveRev) begin
        pos_q <= pos_q + 32'h1;
      end else if (stepDiv_q == 2'h3 && driveRev && !driveFwd) begin
        pos_q <= pos_q - 32'h1;
      end
    end
  end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the axis mode and setting supervisor.
// Assumes the drive model closes the position loop; inputs change at falling edges.
`timescale 1ns/1ps
module testbench;
  logic mclk, reset_n, paramLoad, paramOk, startCmd, stopCmd, driveEnable, refDirNeg;
  logic keyPos, keyNeg, enableIn, refMark, setReq, approachOn, approachOff, approachNeg;
  logic ignoreEnOn, ignoreEnOff, driveFwd, driveRev, paramValid, modeActive, synced;
  logic startRefused, distError, modeDone, modeAborted, setDone, setRefused;
  logic approachActive, approachDirNeg, ignoreEnable, done;
  logic [1:0] modeSel, setSel;
  axis_ctrl_pkg::pos_t incValue, refCoord, setValue, posCount, actualPosition, offset, maxPos, keep;
  int miscompares, checked;

  axis_mode_and_setting_control uut (.mclk(mclk), .reset_n(reset_n), .paramLoad(paramLoad),
    .paramOk(paramOk), .modeSel(modeSel), .startCmd(startCmd), .stopCmd(stopCmd),
    .driveEnable(driveEnable), .incValue(incValue), .refDirNeg(refDirNeg), .refCoord(refCoord),
    .keyPos(keyPos), .keyNeg(keyNeg), .enableIn(enableIn), .refMark(refMark), .setReq(setReq),
    .setSel(setSel), .setValue(setValue), .approachOn(approachOn), .approachOff(approachOff),
    .approachNeg(approachNeg), .ignoreEnOn(ignoreEnOn), .ignoreEnOff(ignoreEnOff),
    .posCount(posCount), .driveFwd(driveFwd), .driveRev(driveRev), .paramValid(paramValid),
    .modeActive(modeActive), .synced(synced), .startRefused(startRefused), .distError(distError),
    .modeDone(modeDone), .modeAborted(modeAborted), .setDone(setDone), .setRefused(setRefused),
    .approachActive(approachActive), .approachDirNeg(approachDirNeg),
    .ignoreEnable(ignoreEnable), .actualPosition(actualPosition), .offset(offset));

  axis_drive_model drive (.mclk(mclk), .reset_n(reset_n), .driveFwd(driveFwd),
    .driveRev(driveRev), .posCount(posCount));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic close_out();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic endtest(input string name);
    $display("test %s finished", name);
  endtask

  // Mode start (s=0) or setting (s=1) pulse; returns at the falling edge after the answer
  task automatic req(input logic s, input logic [1:0] sel, input axis_ctrl_pkg::pos_t v);
    @(negedge mclk);
    if (s) begin
      setReq = 1'b1;
      setSel = sel;
      setValue = v;
    end else begin
      startCmd = 1'b1;
      modeSel = sel;
      incValue = v;
      refCoord = v;
    end
    @(negedge mclk);
    setReq = 1'b0;
    startCmd = 1'b0;
  endtask

  // Single setting pulses: approach on/off, ignore enable on/off
  task automatic single(input logic [3:0] p);
    @(negedge mclk);
    {approachOn, approachOff, ignoreEnOn, ignoreEnOff} = p;
    @(negedge mclk);
    {approachOn, approachOff, ignoreEnOn, ignoreEnOff} = 4'h0;
    @(posedge mclk);
    #1;
  endtask

  // Drive enable and enable pin, then let the pin clear the synchroniser
  task automatic cond(input logic de, input logic en);
    @(negedge mclk);
    driveEnable = de;
    enableIn = en;
    repeat (5) @(negedge mclk);
  endtask

  task automatic wait_done(input int lim);
    int i;
    done = 1'b0;
    maxPos = actualPosition;
    for (i = 0; i < lim && done !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
      if (actualPosition > maxPos) maxPos = actualPosition;
      done = modeDone;
    end
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    close_out();
  end

  initial begin
    {paramLoad, paramOk, startCmd, stopCmd, driveEnable, refDirNeg, refMark} = 7'h0;
    {keyPos, keyNeg, enableIn, setReq, approachOn, approachOff, ignoreEnOn, ignoreEnOff} = 8'h0;
    approachNeg = 1'b1;
    modeSel = 2'h0;
    setSel = 2'h0;
    incValue = 32'h0;
    refCoord = 32'h0;
    setValue = 32'h0;
    miscompares = 0;
    checked = 0;
    reset_n = 1'b0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    chk(paramValid, 1'b0);
    chk(modeActive, 1'b0);
    cond(1'b1, 1'b1);
    req(1'b0, axis_ctrl_pkg::MODE_REL, 32'h5);
    chk(startRefused, 1'b1);
    chk(modeActive, 1'b0);
    req(1'b1, axis_ctrl_pkg::SET_ACTUAL, 32'h7);
    chk(setRefused, 1'b1);
    chk(offset, 32'h0);
    endtest("unparameterized");

    @(negedge mclk);
    paramOk = 1'b1;
    paramLoad = 1'b1;
    @(negedge mclk);
    paramLoad = 1'b0;
    chk(paramValid, 1'b1);
    cond(1'b0, 1'b1);
    req(1'b0, axis_ctrl_pkg::MODE_REL, 32'h5);
    chk(startRefused, 1'b1);
    chk(driveFwd, 1'b0);
    cond(1'b1, 1'b0);
    req(1'b0, axis_ctrl_pkg::MODE_REL, 32'h5);
    chk(startRefused, 1'b1);
    chk(modeActive, 1'b0);
    single(4'h2);
    chk(ignoreEnable, 1'b1);
    req(1'b0, axis_ctrl_pkg::MODE_REL, 32'h3);
    chk(modeActive, 1'b1);
    wait_done(200);
    chk(actualPosition, 32'h3);
    single(4'h1);
    chk(ignoreEnable, 1'b0);
    cond(1'b1, 1'b1);
    endtest("start conditions");

    req(1'b0, axis_ctrl_pkg::MODE_REL, 32'h5);
    chk({modeActive, driveFwd}, 2'h3);
    req(1'b0, axis_ctrl_pkg::MODE_ABS, 32'h40);
    chk(startRefused, 1'b1);
    wait_done(200);
    chk(actualPosition, 32'h8);
    req(1'b0, axis_ctrl_pkg::MODE_REL, 32'hfffffffe);
    chk({distError, modeActive}, 2'h2);
    req(1'b0, axis_ctrl_pkg::MODE_ABS, 32'h40);
    wait_done(400);
    chk(actualPosition, 32'h40);
    endtest("incremental");

    @(negedge mclk);
    modeSel = axis_ctrl_pkg::MODE_JOG;
    for (int d = 0; d < 2; d++) begin
      @(negedge mclk);
      keyPos = (d == 0);
      keyNeg = (d == 1);
      repeat (8) @(posedge mclk);
      #1;
      chk({modeActive, driveFwd, driveRev}, (d == 0) ? 3'h6 : 3'h5);
      @(negedge mclk);
      keyPos = 1'b0;
      keyNeg = 1'b0;
      wait_done(20);
      chk({done, driveFwd, driveRev}, 3'h4);
    end
    endtest("jogging");

    req(1'b0, axis_ctrl_pkg::MODE_REF, 32'h100);
    chk(modeActive, 1'b1);
    repeat (10) @(negedge mclk);
    refMark = 1'b1;
    wait_done(20);
    @(posedge mclk);
    #1;
    keep = actualPosition - 32'h100;
    chk({done, synced, (keep == 32'h0) || (keep == 32'h1)}, 3'h7);
    @(negedge mclk);
    refMark = 1'b0;
    endtest("reference search");

    single(4'h8);
    chk({approachActive, approachDirNeg}, 2'h3);
    req(1'b0, axis_ctrl_pkg::MODE_ABS, 32'h120);
    wait_done(600);
    chk(maxPos, 32'h120 + axis_ctrl_pkg::APPROACH_GAP);
    chk(actualPosition, 32'h120);
    chk(approachActive, 1'b1);
    single(4'h4);
    chk(approachActive, 1'b0);
    endtest("approach direction");

    req(1'b1, axis_ctrl_pkg::SET_ACTUAL, 32'h1000);
    chk(setDone, 1'b1);
    chk(offset, 32'h1000 - posCount);
    @(posedge mclk);
    #1;
    chk(actualPosition, 32'h1000);
    keep = offset;
    req(1'b1, axis_ctrl_pkg::SET_SHIFT, 32'h10);
    repeat (20) @(posedge mclk);
    #1;
    chk(offset, keep + 32'h10);
    req(1'b1, axis_ctrl_pkg::SET_CLEAR, 32'h0);
    chk(offset, 32'h0);
    req(1'b1, axis_ctrl_pkg::SET_REFPT, 32'h20);
    chk({setDone, synced}, 2'h3);
    endtest("settings");

    for (int k = 0; k < 2; k++) begin
      req(1'b0, axis_ctrl_pkg::MODE_REL, 32'h1000);
      @(negedge mclk);
      stopCmd = (k == 0);
      driveEnable = (k == 0);
      @(negedge mclk);
      chk({modeAborted, modeActive, driveFwd}, 3'h4);
      stopCmd = 1'b0;
      driveEnable = 1'b1;
    end
    req(1'b0, axis_ctrl_pkg::MODE_REL, 32'h1000);
    @(negedge mclk);
    reset_n = 1'b0;
    @(negedge mclk);
    reset_n = 1'b1;
    chk({paramValid, modeActive}, 2'h0);
    endtest("abort and reset");
    close_out();
  end
endmodule
